// file: hw/plpr_defines.svh
// Constants for the low-power extended capability register bank
// What this block does
// RULE1: The upstream port holds a writable ten-bit no-snoop latency value in bits 25:16 of dword 234h, zero after reset.
// RULE2: The upstream port holds a writable three-bit no-snoop latency scale in bits 28:26, zero after reset.
// RULE3: The no-snoop latency fields exist only on the upstream port, in the dword at offset 234h.
// RULE4: Bits 15:0 of the substates capability header always read as identifier 001Eh.
// RULE5: Bits 19:16 of the substates header and the containment header always read as version 1h.
// RULE6: The substates header next pointer reads 260h on the upstream port and 250h on downstream ports.
// RULE7: Capability bit 1 reports PCI-PM L1.1 support, read-only, one after reset, reloadable from EEPROM.
// RULE8: Capability bit 3 reports ASPM L1.1 support, read-only, zero after reset, reloadable from SMBus or EEPROM.
// RULE9: Capability bit 4 reports substates support, read-only, one after reset, reloadable from EEPROM.
// RULE10: Control 1 bit 1 is a writable PCI-PM L1.1 enable, zero after reset, on every port.
// RULE11: Control 1 bit 3 is a writable ASPM L1.1 enable, zero after reset, on every port.
// RULE12: On downstream ports bits 15:0 of the containment header read as identifier 001Dh.
// RULE13: The containment header next pointer reads zero to end the capability chain.
// RULE14: The low half of the upstream latency dword holds a writable snoop value in bits 9:0 and scale in bits 12:10.
// RULE15: Reserved bits and all of control 2 read zero, and writes to read-only or reserved bits change nothing.
`ifndef PLPR_DEFINES_SVH
`define PLPR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define PLPR_OFF_LATENCY      12'h234
`define PLPR_OFF_SUB_HEADER   12'h240
`define PLPR_OFF_SUB_FLAGS    12'h244
`define PLPR_OFF_SUB_CTRL1    12'h248
`define PLPR_OFF_SUB_CTRL2    12'h24C
`define PLPR_OFF_CONT_HEADER  12'h250

// ****************************************
// Field positions
// ****************************************
`define PLPR_POS_SNOOP_VAL    0
`define PLPR_POS_SNOOP_SCL    10
`define PLPR_POS_NOSNOOP_VAL  16
`define PLPR_POS_NOSNOOP_SCL  26
`define PLPR_POS_PCIPM_L11    1
`define PLPR_POS_ASPM_L11     3
`define PLPR_POS_SUBSTATES    4

// ****************************************
// Widths and reset values
// ****************************************
`define PLPR_W_LAT_VAL        10
`define PLPR_W_LAT_SCL        3
`define PLPR_RST_LAT_VAL      10'h000
`define PLPR_RST_LAT_SCL      3'h0
`define PLPR_RST_ENABLE       1'h0
`define PLPR_RST_CAP_PCIPM    1'h1
`define PLPR_RST_CAP_ASPM     1'h0
`define PLPR_RST_CAP_SUB      1'h1

// ****************************************
// Fixed header contents
// ****************************************
`define PLPR_ID_SUBSTATES     16'h001E
`define PLPR_ID_CONTAINMENT   16'h001D
`define PLPR_CAP_VERSION      4'h1
`define PLPR_NEXT_SUB_UP      12'h260
`define PLPR_NEXT_SUB_DOWN    12'h250
`define PLPR_NEXT_END         12'h000

`endif

// file: hw/plpr_pkg.sv
// Types shared by the low-power capability register bank
package plpr_pkg;

  // Configuration access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } plpr_cfg_req_t;

  // Configuration access answer
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] rdata;
  } plpr_cfg_rsp_t;

  // Substates capability bits
  typedef struct packed {
    logic pcipm_l11;
    logic aspm_l11;
    logic substates;
  } plpr_cap_bits_t;

  // Decoded register
  typedef enum logic [2:0] {
    PLPR_SEL_NONE,
    PLPR_SEL_LATENCY,
    PLPR_SEL_SUB_HEADER,
    PLPR_SEL_SUB_FLAGS,
    PLPR_SEL_SUB_CTRL1,
    PLPR_SEL_SUB_CTRL2,
    PLPR_SEL_CONT_HEADER
  } plpr_sel_t;

endpackage

// file: hw/plpr_rw_field.sv
// One writable field of a configuration dword, honouring byte enables
`timescale 1ns/1ns
`default_nettype none

module plpr_rw_field #(
  parameter int              WIDTH = 1,
  parameter int              LSB   = 0,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_be,
  input  wire logic [31:0]      wr_data,
  output var  logic [WIDTH-1:0] value
);

  // ****************************************
  // Per-bit storage, lane chosen by position
  // ****************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        value[i] <= RESET[i];
      end else if (wr_en && wr_be[(LSB + i) / 8]) begin
        value[i] <= wr_data[LSB + i];
      end
    end
  end

endmodule

`default_nettype wire

// file: hw/plpr_regs.sv
// Low-power extended capability register bank of one switch port
`timescale 1ns/1ns
`default_nettype none
`include "plpr_defines.svh"

module plpr_regs #(
  parameter bit UPSTREAM_PORT = 1'b1
) (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire plpr_pkg::plpr_cfg_req_t cfg_req,
  output var  plpr_pkg::plpr_cfg_rsp_t cfg_rsp,
  input  wire logic                    eeprom_load_valid,
  input  wire plpr_pkg::plpr_cap_bits_t eeprom_load,
  input  wire logic                    smbus_aspm_valid,
  input  wire logic                    smbus_aspm_value,
  output var  plpr_pkg::plpr_cap_bits_t capability,
  output var  logic                    pcipm_l11_enable,
  output var  logic                    aspm_l11_enable,
  output var  logic [9:0]              snoop_value,
  output var  logic [2:0]              snoop_scale,
  output var  logic [9:0]              nosnoop_value,
  output var  logic [2:0]              nosnoop_scale
);

  // ****************************************
  // Address decode
  // ****************************************
  plpr_pkg::plpr_sel_t sel;
  logic                wr_ok;
  logic                wr_latency;
  logic                wr_ctrl1;
  logic [31:0]         next_rdata;
  logic                next_hit;

  always_comb begin
    sel = plpr_pkg::PLPR_SEL_NONE;
    unique case ({cfg_req.addr[11:2], 2'b00})
      `PLPR_OFF_LATENCY: begin
        // Latency dword only on the upstream port
        if (UPSTREAM_PORT) begin // see RULE3
          sel = plpr_pkg::PLPR_SEL_LATENCY;
        end
      end
      `PLPR_OFF_SUB_HEADER: begin
        sel = plpr_pkg::PLPR_SEL_SUB_HEADER;
      end
      `PLPR_OFF_SUB_FLAGS: begin
        sel = plpr_pkg::PLPR_SEL_SUB_FLAGS;
      end
      `PLPR_OFF_SUB_CTRL1: begin
        sel = plpr_pkg::PLPR_SEL_SUB_CTRL1;
      end
      `PLPR_OFF_SUB_CTRL2: begin
        sel = plpr_pkg::PLPR_SEL_SUB_CTRL2;
      end
      `PLPR_OFF_CONT_HEADER: begin
        // Containment header only on downstream ports
        if (!UPSTREAM_PORT) begin // see RULE12
          sel = plpr_pkg::PLPR_SEL_CONT_HEADER;
        end
      end
      default: begin
        sel = plpr_pkg::PLPR_SEL_NONE;
      end
    endcase
  end

  // ****************************************
  // Write strobes
  // ****************************************
  assign wr_ok      = cfg_req.valid && cfg_req.write;
  assign wr_latency = wr_ok && (sel == plpr_pkg::PLPR_SEL_LATENCY); // see RULE3
  assign wr_ctrl1   = wr_ok && (sel == plpr_pkg::PLPR_SEL_SUB_CTRL1);

  // ****************************************
  // Latency dword fields
  // ****************************************
  plpr_rw_field #(
    .WIDTH (`PLPR_W_LAT_VAL),
    .LSB   (`PLPR_POS_SNOOP_VAL),
    .RESET (`PLPR_RST_LAT_VAL)
  ) u_snoop_value (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_latency), // see RULE14
    .wr_be   (cfg_req.be),
    .wr_data (cfg_req.wdata),
    .value   (snoop_value)
  );

  plpr_rw_field #(
    .WIDTH (`PLPR_W_LAT_SCL),
    .LSB   (`PLPR_POS_SNOOP_SCL),
    .RESET (`PLPR_RST_LAT_SCL)
  ) u_snoop_scale (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_latency), // see RULE14
    .wr_be   (cfg_req.be),
    .wr_data (cfg_req.wdata),
    .value   (snoop_scale)
  );

  plpr_rw_field #(
    .WIDTH (`PLPR_W_LAT_VAL),
    .LSB   (`PLPR_POS_NOSNOOP_VAL),
    .RESET (`PLPR_RST_LAT_VAL)
  ) u_nosnoop_value (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_latency), // see RULE1
    .wr_be   (cfg_req.be),
    .wr_data (cfg_req.wdata),
    .value   (nosnoop_value)
  );

  plpr_rw_field #(
    .WIDTH (`PLPR_W_LAT_SCL),
    .LSB   (`PLPR_POS_NOSNOOP_SCL),
    .RESET (`PLPR_RST_LAT_SCL)
  ) u_nosnoop_scale (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_latency), // see RULE2
    .wr_be   (cfg_req.be),
    .wr_data (cfg_req.wdata),
    .value   (nosnoop_scale)
  );

  // ****************************************
  // Control 1 enables
  // ****************************************
  plpr_rw_field #(
    .WIDTH (1),
    .LSB   (`PLPR_POS_PCIPM_L11),
    .RESET (`PLPR_RST_ENABLE)
  ) u_pcipm_enable (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_ctrl1), // see RULE10
    .wr_be   (cfg_req.be),
    .wr_data (cfg_req.wdata),
    .value   (pcipm_l11_enable)
  );

  plpr_rw_field #(
    .WIDTH (1),
    .LSB   (`PLPR_POS_ASPM_L11),
    .RESET (`PLPR_RST_ENABLE)
  ) u_aspm_enable (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (wr_ctrl1), // see RULE11
    .wr_be   (cfg_req.be),
    .wr_data (cfg_req.wdata),
    .value   (aspm_l11_enable)
  );

  // ****************************************
  // Capability bits with default loading
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      capability.pcipm_l11 <= `PLPR_RST_CAP_PCIPM; // see RULE7
    end else if (eeprom_load_valid) begin
      capability.pcipm_l11 <= eeprom_load.pcipm_l11; // see RULE7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      capability.aspm_l11 <= `PLPR_RST_CAP_ASPM; // see RULE8
    end else if (eeprom_load_valid) begin
      capability.aspm_l11 <= eeprom_load.aspm_l11; // see RULE8
    end else if (smbus_aspm_valid) begin
      capability.aspm_l11 <= smbus_aspm_value; // see RULE8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      capability.substates <= `PLPR_RST_CAP_SUB; // see RULE9
    end else if (eeprom_load_valid) begin
      capability.substates <= eeprom_load.substates; // see RULE9
    end
  end

  // ****************************************
  // Read data assembly
  // ****************************************
  always_comb begin
    next_rdata = 32'h0000_0000; // see RULE15
    next_hit   = 1'b1;
    unique case (sel)
      plpr_pkg::PLPR_SEL_LATENCY: begin
        next_rdata[`PLPR_POS_SNOOP_VAL +: `PLPR_W_LAT_VAL]   = snoop_value; // see RULE14
        next_rdata[`PLPR_POS_SNOOP_SCL +: `PLPR_W_LAT_SCL]   = snoop_scale; // see RULE14
        next_rdata[`PLPR_POS_NOSNOOP_VAL +: `PLPR_W_LAT_VAL] = nosnoop_value; // see RULE1
        next_rdata[`PLPR_POS_NOSNOOP_SCL +: `PLPR_W_LAT_SCL] = nosnoop_scale; // see RULE2
      end
      plpr_pkg::PLPR_SEL_SUB_HEADER: begin
        next_rdata[15:0]  = `PLPR_ID_SUBSTATES; // see RULE4
        next_rdata[19:16] = `PLPR_CAP_VERSION; // see RULE5
        next_rdata[31:20] = UPSTREAM_PORT ? `PLPR_NEXT_SUB_UP
                                          : `PLPR_NEXT_SUB_DOWN; // see RULE6
      end
      plpr_pkg::PLPR_SEL_SUB_FLAGS: begin
        next_rdata[`PLPR_POS_PCIPM_L11] = capability.pcipm_l11; // see RULE7
        next_rdata[`PLPR_POS_ASPM_L11]  = capability.aspm_l11; // see RULE8
        next_rdata[`PLPR_POS_SUBSTATES] = capability.substates; // see RULE9
      end
      plpr_pkg::PLPR_SEL_SUB_CTRL1: begin
        next_rdata[`PLPR_POS_PCIPM_L11] = pcipm_l11_enable; // see RULE10
        next_rdata[`PLPR_POS_ASPM_L11]  = aspm_l11_enable; // see RULE11
      end
      plpr_pkg::PLPR_SEL_SUB_CTRL2: begin
        next_rdata = 32'h0000_0000; // see RULE15
      end
      plpr_pkg::PLPR_SEL_CONT_HEADER: begin
        next_rdata[15:0]  = `PLPR_ID_CONTAINMENT; // see RULE12
        next_rdata[19:16] = `PLPR_CAP_VERSION; // see RULE5
        next_rdata[31:20] = `PLPR_NEXT_END; // see RULE13
      end
      plpr_pkg::PLPR_SEL_NONE: begin
        next_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Answer register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_rsp.valid <= 1'b0;
    end else begin
      cfg_rsp.valid <= cfg_req.valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_rsp.hit   <= 1'b0;
      cfg_rsp.rdata <= 32'h0000_0000;
    end else if (cfg_req.valid) begin
      cfg_rsp.hit   <= next_hit;
      cfg_rsp.rdata <= cfg_req.write ? 32'h0000_0000 : next_rdata;
    end
  end

endmodule

`default_nettype wire

// file: verification/plpr_regs_chk.sv
// Checker for the low-power capability register bank
`timescale 1ns/1ns
`default_nettype none

module plpr_regs_chk #(
  parameter bit UPSTREAM_PORT = 1'b1
) (
  input wire logic                     sys_clk,
  input wire logic                     srst,
  input wire plpr_pkg::plpr_cfg_req_t  cfg_req,
  input wire plpr_pkg::plpr_cfg_rsp_t  cfg_rsp,
  input wire logic                     eeprom_load_valid,
  input wire plpr_pkg::plpr_cap_bits_t eeprom_load,
  input wire logic                     smbus_aspm_valid,
  input wire logic                     smbus_aspm_value,
  input wire plpr_pkg::plpr_cap_bits_t capability,
  input wire logic                     pcipm_l11_enable,
  input wire logic                     aspm_l11_enable,
  input wire logic [9:0]               snoop_value,
  input wire logic [2:0]               snoop_scale,
  input wire logic [9:0]               nosnoop_value,
  input wire logic [2:0]               nosnoop_scale
);
  // ****************************************
  // Helpers
  // ****************************************
  logic       rd;
  logic       wr;
  logic [9:0] dw;
  logic [2:0] cap_q;
  assign rd = cfg_req.valid & ~cfg_req.write;
  assign wr = cfg_req.valid & cfg_req.write;
  assign dw = cfg_req.addr[11:2];
  always_ff @(posedge sys_clk) begin
    cap_q <= capability;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  answer_pulse_a: assert property (cfg_rsp.valid ==
    ($past(cfg_req.valid) && !$past(srst))) else $error("answer pulse wrong");
  sub_header_a: assert property (rd && dw == 10'h090 |=> cfg_rsp.hit &&
    cfg_rsp.rdata == {(UPSTREAM_PORT ? 12'h260 : 12'h250), 20'h1001E}) else $error("header wrong");
  ctrl2_zero_a: assert property (rd && dw == 10'h093 |=>
    cfg_rsp.hit && cfg_rsp.rdata == 32'h0) else $error("control 2 not zero");
  cont_header_a: assert property (rd && dw == 10'h094 |=>
    cfg_rsp.hit == !UPSTREAM_PORT &&
    cfg_rsp.rdata == (UPSTREAM_PORT ? 32'h0 : 32'h0001001D))
    else $error("containment header wrong");
  cap_read_a: assert property (rd && dw == 10'h091 |=>
    cfg_rsp.rdata == {27'h0, cap_q[0], cap_q[1], 1'b0, cap_q[2], 1'b0}) else $error("flags wrong");
  ctrl_write_a: assert property (wr && dw == 10'h092 && cfg_req.be[0] |=>
    {aspm_l11_enable, pcipm_l11_enable} == {$past(cfg_req.wdata[3]), $past(cfg_req.wdata[1])})
    else $error("enable write lost");
  nosnoop_write_a: assert property (UPSTREAM_PORT && wr && dw == 10'h08D &&
    cfg_req.be[3:2] == 2'h3 |=> {nosnoop_scale, nosnoop_value} == $past(cfg_req.wdata[28:16]))
    else $error("latency write lost");
  reset_values_a: assert property (disable iff (1'b0) srst |=> capability == 3'h5 &&
    !pcipm_l11_enable && !aspm_l11_enable && nosnoop_value == 10'h0 && nosnoop_scale == 3'h0)
    else $error("reset values wrong");
  eeprom_load_a: assert property (eeprom_load_valid |=>
    capability == $past(eeprom_load)) else $error("eeprom load lost");
  smbus_load_a: assert property (smbus_aspm_valid && !eeprom_load_valid |=>
    capability.aspm_l11 == $past(smbus_aspm_value)) else $error("smbus load lost");
  cover property (wr && dw == 10'h092);
  cover property (eeprom_load_valid);
  cover property (smbus_aspm_valid && !eeprom_load_valid);
endmodule

bind plpr_regs plpr_regs_chk #(.UPSTREAM_PORT(UPSTREAM_PORT)) u_chk (
  .sys_clk(sys_clk), .srst(srst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
  .eeprom_load_valid(eeprom_load_valid), .eeprom_load(eeprom_load),
  .smbus_aspm_valid(smbus_aspm_valid), .smbus_aspm_value(smbus_aspm_value),
  .capability(capability), .pcipm_l11_enable(pcipm_l11_enable), .aspm_l11_enable(aspm_l11_enable),
  .snoop_value(snoop_value), .snoop_scale(snoop_scale), .nosnoop_value(nosnoop_value),
  .nosnoop_scale(nosnoop_scale));
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the low-power capability register bank
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic                     sys_clk, srst, ev, sv, sa, pe, ae;
  plpr_pkg::plpr_cfg_req_t  cfg_req;
  plpr_pkg::plpr_cfg_rsp_t  rsp_up, rsp_dn;
  plpr_pkg::plpr_cap_bits_t ed, capability;
  logic [9:0]               snv, nsv;
  logic [2:0]               sns, nss, cap;
  logic [31:0]              lat, ctl;
  logic [15:0]              lfsr;
  logic [11:0]              addrs [8] = '{12'h234, 12'h238, 12'h240, 12'h244, 12'h248, 12'h24C,
                                          12'h250, 12'h254};
  int                       n_errors, samples_checked;

  plpr_regs #(.UPSTREAM_PORT(1'b1)) u_dut (.sys_clk(sys_clk), .srst(srst), .cfg_req(cfg_req),
    .cfg_rsp(rsp_up), .eeprom_load_valid(ev), .eeprom_load(ed), .smbus_aspm_valid(sv),
    .smbus_aspm_value(sa), .capability(capability), .pcipm_l11_enable(pe), .aspm_l11_enable(ae),
    .snoop_value(snv), .snoop_scale(sns), .nosnoop_value(nsv), .nosnoop_scale(nss));
  plpr_regs #(.UPSTREAM_PORT(1'b0)) u_dn (.sys_clk(sys_clk), .srst(srst), .cfg_req(cfg_req),
    .cfg_rsp(rsp_dn), .eeprom_load_valid(ev), .eeprom_load(ed), .smbus_aspm_valid(sv),
    .smbus_aspm_value(sa), .capability(), .pcipm_l11_enable(), .aspm_l11_enable(),
    .snoop_value(), .snoop_scale(), .nosnoop_value(), .nosnoop_scale());

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [32:0] expect_rd(input bit up, input logic [11:0] a);
    case (a)
      12'h234: return up ? {1'b1, lat} : 33'h0;
      12'h240: return {1'b1, (up ? 12'h260 : 12'h250), 20'h1001E};
      12'h244: return {1'b1, 27'h0, cap[0], cap[1], 1'b0, cap[2], 1'b0};
      12'h248: return {1'b1, ctl};
      12'h24C: return {1'b1, 32'h0};
      12'h250: return up ? 33'h0 : {1'b1, 32'h0001001D};
      default: return 33'h0;
    endcase
  endfunction

  task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic outs();
    cmp("outputs", {cap, ctl[3], ctl[1], lat[28:16], lat[12:0]},
        {capability, ae, pe, nss, nsv, sns, snv});
  endtask

  task automatic access(input logic wr, input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] wd);
    logic [32:0] eu, edn;
    logic [31:0] m;
    @(negedge sys_clk);
    cfg_req = '{1'b1, wr, a, be, wd};
    @(negedge sys_clk);
    cfg_req.valid = 1'b0;
    eu = expect_rd(1'b1, a);
    edn = expect_rd(1'b0, a);
    if (wr) begin
      eu[31:0] = 32'h0;
      edn[31:0] = 32'h0;
    end
    cmp("upstream answer", {1'b1, eu}, rsp_up);
    cmp("downstream answer", {1'b1, edn}, rsp_dn);
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & {32{wr}};
    if (a == 12'h234) lat = (lat & ~(m & 32'h1FFF1FFF)) | (wd & m & 32'h1FFF1FFF);
    if (a == 12'h248) ctl = (ctl & ~(m & 32'hA)) | (wd & m & 32'hA);
    outs();
  endtask

  task automatic load(input logic e, input logic [2:0] d, input logic s, input logic v);
    @(negedge sys_clk);
    {ev, ed, sv, sa} = {e, d, s, v};
    @(negedge sys_clk);
    {ev, sv} = 2'h0;
    if (s) cap[1] = v;
    if (e) cap = d;
    outs();
  endtask

  task automatic do_reset(input int n);
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (n) @(negedge sys_clk);
    srst = 1'b0;
    {lat, ctl, cap} = {64'h0, 3'h5};
  endtask

  task automatic read_all();
    foreach (addrs[i]) access(1'b0, addrs[i], 4'hF, 32'h0);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    final_report();
  end

  initial begin
    {ev, ed, sv, sa, cfg_req} = '0;
    srst = 1'b1;
    lfsr = 16'h1AD6;
    do_reset(11);
    read_all();
    $display("test reset values done");
    access(1'b1, 12'h248, 4'hF, 32'hFFFFFFFF);
    access(1'b1, 12'h248, 4'hE, 32'h00000000);
    foreach (addrs[i]) access(1'b1, addrs[i], 4'hF, 32'hFFFFFFFF);
    read_all();
    $display("test fixed writes done");
    repeat (80) begin
      lfsr = lfsr_next(lfsr);
      access(lfsr[3], addrs[lfsr[6:4]], lfsr[11:8], {lfsr, lfsr_next(lfsr)});
    end
    $display("test random accesses done");
    load(1'b1, 3'h2, 1'b0, 1'b0);
    load(1'b0, 3'h0, 1'b1, 1'b1);
    load(1'b1, 3'h5, 1'b1, 1'b1);
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      load(lfsr[0], lfsr[3:1], lfsr[4], lfsr[5]);
      access(1'b0, 12'h244, 4'hF, 32'h0);
    end
    $display("test capability loads done");
    do_reset(1);
    read_all();
    $display("test second reset done");
    final_report();
  end
endmodule
`default_nettype wire
